// ==== inc/cal_cfg.svh ====
// Constants shared by both ends of the chip-select to command latency link
`ifndef CAL_CFG_SVH
`define CAL_CFG_SVH

// ----------------------------------------------------------------
// Link field widths
// ----------------------------------------------------------------
`define CMD_W 3
`define ADDR_W 14
`define BA_W 2

// ----------------------------------------------------------------
// Command codes and mode register selection
// ----------------------------------------------------------------
`define CMD_DESELECT 3'h0
`define CMD_MODESET 3'h1
`define BA_MODE_REG_ONE 2'h1

// ----------------------------------------------------------------
// Latency field inside mode_register_one
// ----------------------------------------------------------------
`define CAL_LSB 0
`define CAL_W 3
`define CAL_RESET 3'h0
`define MR1_RESET 14'h0000
`define HIST_W 8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define MODESET_UPDATE_NS 240
`define MODESET_UPDATE_CYC ((`MODESET_UPDATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAIT_W 6

`endif

// ==== inc/cal_pkg.sv ====
// Types and helpers shared by both ends of the latency link
package cal_pkg;
    `include "cal_cfg.svh"

    typedef logic [`CMD_W-1:0] cmd_code_t;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`BA_W-1:0] ba_t;
    typedef logic [`CAL_W-1:0] cal_t;
    typedef logic [`WAIT_W-1:0] wait_t;

    // Latency field of a mode_register_one write
    function automatic cal_t cal_from_addr(input addr_t a);
        cal_from_addr = a[`CAL_LSB +: `CAL_W];
    endfunction

    // Mode-set recovery: update delay plus the latency in force
    function automatic wait_t modeset_wait(input cal_t c);
        modeset_wait = wait_t'(`MODESET_UPDATE_CYC) + wait_t'(c);
    endfunction

    // True for a write of mode_register_one
    function automatic logic is_mr1_write(input cmd_code_t c, input ba_t b);
        is_mr1_write = (c == `CMD_MODESET) && (b == `BA_MODE_REG_ONE);
    endfunction
endpackage

// ==== inc/cal_if.sv ====
// Command and address link between controller and memory device
`timescale 1ns/1ns
interface cal_if;
    import cal_pkg::*;
    logic cs_n;
    cmd_code_t cmd;
    addr_t addr;
    ba_t ba;
    logic odt;

    modport device (input cs_n, input cmd, input addr, input ba, input odt);
    modport host (output cs_n, output cmd, output addr, output ba, output odt);
endinterface

// ==== rtl/cal_device.sv ====
// Device end: delayed command capture, receiver gating and mode-set recovery
// Summary of operation
// [RULE1] Capture command the programmed cycles after select
// [RULE2] Mode register write switches latency on, off
// [RULE3] Latency value is whole clock cycles
// [RULE4] Select low starts enabling command receivers
// [RULE5] Receivers off after capture if select high
// [RULE6] Receivers stay on through consecutive selects
// [RULE7] Next command waits update delay plus latency
// [RULE8] Next mode write waits update delay plus latency
// [RULE9] Recovery uses the newly programmed latency
// [RULE10] Termination timing unchanged by latency
// [RULE11] Base update delay precedes any valid command
// [RULE12] Latency off: same-edge capture, receivers always on
`timescale 1ns/1ns
module cal_device import cal_pkg::*; (
    input wire logic sys_clk,            // System clock
    input wire logic rst,                // Async reset, active high
    cal_if.device link,                  // Link from controller
    output logic cmd_valid,              // Captured command strobe
    output cmd_code_t cmd_code,          // Captured command code
    output addr_t cmd_addr,              // Captured address
    output ba_t cmd_ba,                  // Captured register select
    output logic rx_enable,              // Command receivers powered
    output logic odt_active,             // Termination control
    output cal_t cal_value,              // Latency in force
    output logic cal_on,                 // Latency feature enabled
    output logic modeset_busy,           // Mode-set recovery running
    output logic early_cmd               // Command inside recovery window
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [`HIST_W-1:0] hist_reg, hist_next;
    addr_t mr1_reg, mr1_next;
    logic valid_reg, valid_next;
    cmd_code_t code_reg, code_next;
    addr_t addr_reg, addr_next;
    ba_t ba_reg, ba_next;
    logic rx_reg, rx_next;
    logic odt_reg, odt_next;
    wait_t busy_reg, busy_next;
    logic early_reg, early_next;
    logic capture;
    logic [`HIST_W-1:0] pending_mask;
    logic [`HIST_W-1:0] hist_kept;
    cal_t cal_now;
    cal_t cal_new;

    // ----------------------------------------------------------------
    // Capture decision
    // ----------------------------------------------------------------

    // Latency taken from stored mode register, in clocks
    assign cal_now = cal_from_addr(mr1_reg); // see [RULE3]

    // Capture edge: same edge when off, else delayed by latency
    always_comb begin
        if (cal_now == `CAL_RESET) begin
            capture = ~link.cs_n; // see [RULE12]
        end else begin
            capture = hist_reg[cal_now - 3'h1]; // see [RULE1]
        end
    end

    // Selects still waiting for their command after this edge
    always_comb begin
        pending_mask = '0;
        for (int k = 0; k < `HIST_W; k++) begin
            if (k + 1 <= int'(cal_now)) begin
                pending_mask[k] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    // Select history, capture, mode register and receiver gating
    always_comb begin
        // Retire the select served at this edge
        hist_kept = hist_reg;
        if (cal_now != `CAL_RESET) begin
            hist_kept[cal_now - 3'h1] = 1'b0;
        end
        // Same-edge selects are not recorded
        hist_next = {hist_kept[`HIST_W-2:0], ~link.cs_n & (cal_now != `CAL_RESET)};
        mr1_next = mr1_reg;
        valid_next = capture;
        code_next = code_reg;
        addr_next = addr_reg;
        ba_next = ba_reg;
        cal_new = cal_now;
        busy_next = (busy_reg != '0) ? busy_reg - wait_t'(1) : busy_reg;
        early_next = 1'b0;
        if (capture) begin
            code_next = link.cmd; // see [RULE1]
            addr_next = link.addr;
            ba_next = link.ba;
            early_next = (busy_reg != '0) && (link.cmd != `CMD_DESELECT); // see [RULE7]
            if (is_mr1_write(link.cmd, link.ba)) begin
                mr1_next = link.addr; // see [RULE2]
                cal_new = cal_from_addr(link.addr);
            end
            if (link.cmd == `CMD_MODESET) begin
                // Recovery sized with the latency in force after this write
                if (cal_new != `CAL_RESET) begin
                    busy_next = modeset_wait(cal_new); // see [RULE8] see [RULE9]
                end else begin
                    busy_next = wait_t'(`MODESET_UPDATE_CYC); // see [RULE11]
                end
            end
        end
        // Receivers: always on when off, else while selects are pending
        if (cal_from_addr(mr1_next) == `CAL_RESET) begin
            rx_next = 1'b1; // see [RULE12]
        end else begin
            rx_next = ~link.cs_n // see [RULE4] see [RULE6]
                | (|(hist_next & pending_mask)); // see [RULE5]
        end
        // Termination follows the pin with no latency added
        odt_next = link.odt; // see [RULE10]
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------

    // Register all state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hist_reg <= '0;
            mr1_reg <= `MR1_RESET;
            valid_reg <= 1'b0;
            code_reg <= `CMD_DESELECT;
            addr_reg <= '0;
            ba_reg <= '0;
            rx_reg <= 1'b1;
            odt_reg <= 1'b0;
            busy_reg <= '0;
            early_reg <= 1'b0;
        end else begin
            hist_reg <= hist_next;
            mr1_reg <= mr1_next;
            valid_reg <= valid_next;
            code_reg <= code_next;
            addr_reg <= addr_next;
            ba_reg <= ba_next;
            rx_reg <= rx_next;
            odt_reg <= odt_next;
            busy_reg <= busy_next;
            early_reg <= early_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    // Outputs from flops; cal_on and modeset_busy decoded from register values
    assign cmd_valid = valid_reg;
    assign cmd_code = code_reg;
    assign cmd_addr = addr_reg;
    assign cmd_ba = ba_reg;
    assign rx_enable = rx_reg;
    assign odt_active = odt_reg;
    assign cal_value = cal_now;
    assign cal_on = (cal_now != `CAL_RESET);
    assign modeset_busy = (busy_reg != '0);
    assign early_cmd = early_reg;

endmodule // cal_device

// ==== rtl/cal_host.sv ====
// Controller end: select lead, delayed command drive and mode-set spacing
`timescale 1ns/1ns
module cal_host import cal_pkg::*; (
    input wire logic sys_clk,            // System clock
    input wire logic rst,                // Async reset, active high
    cal_if.host link,                    // Link to device
    input wire logic req_valid,          // Command request
    output logic req_ready,              // Request taken this edge
    input wire cmd_code_t req_cmd,       // Requested command
    input wire addr_t req_addr,          // Requested address
    input wire ba_t req_ba,              // Requested register select
    input wire logic odt_req             // Termination request
);

    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_WAIT} host_state_t;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    host_state_t state_reg, state_next;
    cal_t cal_reg, cal_next;
    cal_t lead_reg, lead_next;
    wait_t wait_reg, wait_next;
    logic cs_n_reg, cs_n_next;
    cmd_code_t cmd_reg, cmd_next;
    addr_t addr_reg, addr_next;
    ba_t ba_reg, ba_next;
    cmd_code_t hold_cmd_reg, hold_cmd_next;
    addr_t hold_addr_reg, hold_addr_next;
    ba_t hold_ba_reg, hold_ba_next;
    logic odt_reg, odt_next;
    logic issue;
    cal_t cal_after;

    assign req_ready = (state_reg == ST_IDLE);

    // Sequencing of select, command and recovery wait
    always_comb begin
        state_next = state_reg;
        cal_next = cal_reg;
        lead_next = lead_reg;
        wait_next = (wait_reg != '0) ? wait_reg - wait_t'(1) : wait_reg;
        cs_n_next = 1'b1;
        cmd_next = `CMD_DESELECT;
        addr_next = addr_reg;
        ba_next = ba_reg;
        hold_cmd_next = hold_cmd_reg;
        hold_addr_next = hold_addr_reg;
        hold_ba_next = hold_ba_reg;
        issue = 1'b0;
        cal_after = cal_reg;
        odt_next = odt_req; // see [RULE10]
        unique case (state_reg)
            ST_IDLE: begin
                if (req_valid) begin
                    cs_n_next = 1'b0;
                    hold_cmd_next = req_cmd;
                    hold_addr_next = req_addr;
                    hold_ba_next = req_ba;
                    if (cal_reg == `CAL_RESET) begin
                        issue = 1'b1; // see [RULE12]
                    end else begin
                        lead_next = cal_reg; // see [RULE1]
                        state_next = ST_LEAD;
                    end
                end
            end
            ST_LEAD: begin
                lead_next = lead_reg - 3'h1;
                if (lead_reg == 3'h1) begin
                    issue = 1'b1; // see [RULE1]
                end
            end
            ST_WAIT: begin
                if (wait_reg == '0) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
        if (issue) begin
            cmd_next = hold_cmd_next;
            addr_next = hold_addr_next;
            ba_next = hold_ba_next;
            if (is_mr1_write(hold_cmd_next, hold_ba_next)) begin
                cal_after = cal_from_addr(hold_addr_next); // see [RULE2] see [RULE3]
                cal_next = cal_after;
            end
            if (hold_cmd_next == `CMD_MODESET) begin
                wait_next = modeset_wait(cal_after); // see [RULE7] see [RULE8] see [RULE9]
                state_next = ST_WAIT; // see [RULE11]
            end else begin
                state_next = ST_IDLE;
            end
        end
    end

    // Register all state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cal_reg <= `CAL_RESET;
            lead_reg <= '0;
            wait_reg <= '0;
            cs_n_reg <= 1'b1;
            cmd_reg <= `CMD_DESELECT;
            addr_reg <= '0;
            ba_reg <= '0;
            hold_cmd_reg <= `CMD_DESELECT;
            hold_addr_reg <= '0;
            hold_ba_reg <= '0;
            odt_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cal_reg <= cal_next;
            lead_reg <= lead_next;
            wait_reg <= wait_next;
            cs_n_reg <= cs_n_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            ba_reg <= ba_next;
            hold_cmd_reg <= hold_cmd_next;
            hold_addr_reg <= hold_addr_next;
            hold_ba_reg <= hold_ba_next;
            odt_reg <= odt_next;
        end
    end

    // Link pins from flops
    assign link.cs_n = cs_n_reg;
    assign link.cmd = cmd_reg;
    assign link.addr = addr_reg;
    assign link.ba = ba_reg;
    assign link.odt = odt_reg;

endmodule // cal_host

// ==== sim/cal_link_monitor.sv ====
// Checker for the select-to-command latency link
`timescale 1ns/1ns
`include "cal_cfg.svh"
module cal_link_monitor import cal_pkg::*; (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Async reset
    input wire logic cs_n, // Select, active low
    input wire cmd_code_t cmd, // Command code
    input wire addr_t addr, // Address
    input wire ba_t ba, // Register select
    input wire logic odt // Termination request
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [6:0] hist_reg;
    logic [6:0] hist_next;
    cal_t cal_reg;
    cal_t cal_next;
    wait_t rec_reg;
    wait_t rec_next;
    logic [7:0] sel_hist;
    logic [7:0] lead_mask;
    logic due;
    // Select history, latency seen on the wire, recovery count
    always_comb begin
        sel_hist = {hist_reg, ~cs_n};
        due = sel_hist[cal_reg];
        lead_mask = (8'h01 << cal_reg) - 8'h01;
        hist_next = sel_hist[6:0] & ~(7'h01 << cal_reg); // Served select retired
        cal_next = cal_reg;
        rec_next = (rec_reg != 6'h00) ? rec_reg - 6'h01 : rec_reg;
        if (cmd == `CMD_MODESET) begin
            if (ba == `BA_MODE_REG_ONE) begin
                cal_next = addr[`CAL_LSB +: `CAL_W];
            end
            rec_next = wait_t'(`MODESET_UPDATE_CYC) + wait_t'(cal_next) - 6'h01;
        end
    end
    // Register the helper state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hist_reg <= 7'h00;
            cal_reg <= 3'h0;
            rec_reg <= 6'h00;
        end else begin
            hist_reg <= hist_next;
            cal_reg <= cal_next;
            rec_reg <= rec_next;
        end
    end
    cmd_due_a: assert property (due |-> cmd != `CMD_DESELECT)
        else $error("select without command at latency");
    cmd_undue_a: assert property (cmd != `CMD_DESELECT |-> due)
        else $error("command without matching select");
    single_select_a: assert property (!cs_n && cal_reg != 3'h0 |=> cs_n)
        else $error("select held low with latency on");
    lead_gap_a: assert property (!cs_n && cal_reg != 3'h0 |->
        (hist_reg & lead_mask[6:0]) == 7'h00)
        else $error("select inside latency window");
    cmd_single_a: assert property (cmd != `CMD_DESELECT && cal_reg != 3'h0 |=>
        cmd == `CMD_DESELECT)
        else $error("command held over one cycle");
    mod_gap_a: assert property (rec_reg != 6'h00 |-> cmd == `CMD_DESELECT)
        else $error("command inside mode-set recovery");
    mrs_select_a: assert property (rec_reg != 6'h00 |-> cs_n)
        else $error("select inside mode-set recovery");
    reset_idle_a: assert property ($past(rst) |-> cs_n && cmd == `CMD_DESELECT && !odt)
        else $error("link not idle after reset");
    cover property (cmd == `CMD_MODESET && ba == `BA_MODE_REG_ONE);
    cover property (!cs_n && cal_reg == 3'h3);
    cover property (odt && cal_reg != 3'h0);
endmodule // cal_link_monitor

// ==== sim/command_address_latency_ctrl_bench.sv ====
// Self-checking bench for both ends of the latency link
`timescale 1ns/1ns
`include "cal_cfg.svh"
module command_address_latency_ctrl_bench import cal_pkg::*;;
    logic sys_clk, rst, req_valid, req_ready, odt_req, cmd_valid, rx_enable, odt_active;
    logic cal_on, modeset_busy, early_cmd, rx_f, early_f;
    cmd_code_t req_cmd, cmd_code;
    addr_t req_addr, cmd_addr;
    ba_t req_ba, cmd_ba;
    cal_t cal_value;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    int lat;
    cal_if link();
    cal_if link_f();
    cal_host u_cal_host (.sys_clk(sys_clk), .rst(rst), .link(link.host), .req_valid(req_valid),
        .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_ba(req_ba),
        .odt_req(odt_req));
    cal_device u_cal_device (.sys_clk(sys_clk), .rst(rst), .link(link.device),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_ba(cmd_ba),
        .rx_enable(rx_enable), .odt_active(odt_active), .cal_value(cal_value), .cal_on(cal_on),
        .modeset_busy(modeset_busy), .early_cmd(early_cmd));
    cal_device u_cal_device_f (.sys_clk(sys_clk), .rst(rst), .link(link_f.device),
        .cmd_valid(), .cmd_code(), .cmd_addr(), .cmd_ba(), .rx_enable(rx_f), .odt_active(),
        .cal_value(), .cal_on(), .modeset_busy(), .early_cmd(early_f));
    cal_link_monitor u_cal_link_monitor (.sys_clk(sys_clk), .rst(rst), .cs_n(link.cs_n),
        .cmd(link.cmd), .addr(link.addr), .ba(link.ba), .odt(link.odt));
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            $display("[ERR] run_time expected under 2000 seen 2000");
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Request through the host, then count edges until the device capture
    task automatic issue(input cmd_code_t c, input addr_t a, input ba_t b, output int l);
        int k;
        k = 0;
        req_cmd = c;
        req_addr = a;
        req_ba = b;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && k < 100) begin
            tick(1);
            k++;
        end
        tick(1);
        req_valid = 1'b0;
        l = 0;
        while (cmd_valid !== 1'b1 && l < 20) begin
            tick(1);
            l++;
        end
        chk("early_cmd", 16'h0000, 16'(early_cmd));
    endtask
    // Mode set writing v to register b, then measure the recovery window
    task automatic mset(input cal_t v, input ba_t b, input int w);
        int n;
        n = 0;
        issue(`CMD_MODESET, addr_t'(v), b, lat);
        chk("mode set capture", 16'h0001, 16'(cmd_valid));
        while (modeset_busy === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk("recovery cycles", 16'(w), 16'(n));
    endtask
    // One cycle on the second link, driven by the bench
    task automatic fdrv(input logic s, input cmd_code_t c, input addr_t a, input ba_t b);
        link_f.cs_n = s;
        link_f.cmd = c;
        link_f.addr = a;
        link_f.ba = b;
        tick(1);
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        {req_valid, odt_req, req_cmd, req_addr, req_ba} = '0;
        {link_f.cmd, link_f.addr, link_f.ba, link_f.odt} = '0;
        link_f.cs_n = 1'b1;
        tick(2);
        rst = 1'b0;
        chk("rx_enable", 16'h0001, 16'(rx_enable));
        chk("cal_on", 16'h0000, 16'(cal_on));
        chk("req_ready", 16'h0001, 16'(req_ready));
        issue(3'h2, 14'h1A5C, 2'h2, lat);
        chk("latency off", 16'h0001, 16'(lat));
        chk("cmd_addr", 16'h1A5C, 16'(cmd_addr));
        $display("test latency off done");
        mset(3'h3, `BA_MODE_REG_ONE, 27);
        chk("cal_value", 16'h0003, 16'(cal_value));
        tick(2);
        chk("rx idle", 16'h0000, 16'(rx_enable));
        issue(3'h2, 14'h2B6D, 2'h3, lat);
        chk("latency three", 16'h0004, 16'(lat));
        chk("cmd_ba", 16'h0003, 16'(cmd_ba));
        chk("cmd_code", 16'h0002, 16'(cmd_code));
        tick(2);
        chk("rx after capture", 16'h0000, 16'(rx_enable));
        odt_req = 1'b1;
        tick(1);
        chk("link odt", 16'h0001, 16'(link.odt));
        tick(1);
        chk("odt_active", 16'h0001, 16'(odt_active));
        odt_req = 1'b0;
        $display("test latency three done");
        mset(3'h5, `BA_MODE_REG_ONE, 29);
        mset(3'h0, 2'h0, 29);
        mset(3'h0, `BA_MODE_REG_ONE, 24);
        chk("cal_on off", 16'h0000, 16'(cal_on));
        chk("rx always on", 16'h0001, 16'(rx_enable));
        $display("test mode changes done");
        fdrv(1'b0, `CMD_MODESET, 14'h0000, `BA_MODE_REG_ONE);
        fdrv(1'b1, `CMD_DESELECT, 14'h0000, 2'h0);
        fdrv(1'b0, 3'h2, 14'h0000, 2'h0);
        chk("early command", 16'h0001, 16'(early_f));
        fdrv(1'b0, `CMD_MODESET, 14'h0002, `BA_MODE_REG_ONE);
        link_f.cs_n = 1'b1;
        link_f.cmd = `CMD_DESELECT;
        tick(30);
        chk("rx idle far", 16'h0000, 16'(rx_f));
        for (int i = 0; i < 4; i++) begin
            fdrv(i > 2, (i > 1) ? 3'h2 : `CMD_DESELECT, 14'h0000, 2'h0);
            chk("rx consecutive", 16'h0001, 16'(rx_f));
        end
        fdrv(1'b1, 3'h2, 14'h0000, 2'h0);
        link_f.cmd = `CMD_DESELECT;
        chk("rx after run", 16'h0000, 16'(rx_f));
        $display("test far link done");
        conclude();
    end
endmodule // command_address_latency_ctrl_bench
